// ===== inc/ads_defines.vh
// register offsets, field positions and reset values for the address-decoded strobe port
// assumes an 8-bit special function register bus with an 8-bit address, one access per enabled clock
`ifndef ADS_DEFINES_VH
`define ADS_DEFINES_VH

// register offsets
`define ADS_OFS_CTRL01 8'h92
`define ADS_OFS_CTRL23 8'h93
`define ADS_OFS_POLMISC 8'hA2
`define ADS_OFS_LATCH 8'hA3
`define ADS_OFS_BASE0H 8'hA4
`define ADS_OFS_BASE0L 8'hA5
`define ADS_OFS_BASE1H 8'hA6
`define ADS_OFS_BASE1L 8'hA7
`define ADS_OFS_BASE2H 8'hA8
`define ADS_OFS_BASE2L 8'hA9
`define ADS_OFS_BASE3H 8'hAA
`define ADS_OFS_BASE3L 8'hAB

// control register fields, one nibble per pin
`define ADS_NIB_FUNC_HI 3
`define ADS_NIB_FUNC_LO 2
`define ADS_NIB_CMP_HI 1
`define ADS_NIB_CMP_LO 0

// pin function selects
`define ADS_FUNC_GPIO 2'h0
`define ADS_FUNC_RD 2'h1
`define ADS_FUNC_WR 2'h2
`define ADS_FUNC_RDWR 2'h3

// compare width selects
`define ADS_CMP_A15_A0 2'h0
`define ADS_CMP_A15_A1 2'h1
`define ADS_CMP_A15_A2 2'h2
`define ADS_CMP_A15_A8 2'h3

// polarity and misc register fields
`define ADS_POL_LSB 4
`define ADS_BIT_PWDN_LEVEL 2
`define ADS_BIT_RMW_PIN 1
`define ADS_POLMISC_MASK 8'hF6

// reset values
`define ADS_RST_CTRL 8'h00
`define ADS_RST_POLMISC 8'h00
`define ADS_RST_LATCH 8'hFF
`define ADS_RST_BASE 8'h00
`define ADS_RST_RDATA 8'h00

`endif

// ===== hw/ads_strobe_port.v
// four-pin port: quasi-bidirectional I/O or address-decoded chip-select strobes
// assumes an SFR bus and an external data bus whose strobes are synchronous to I_REF_CLK
`timescale 1ns/1ps
`include "ads_defines.vh"

module ads_strobe_port #(
   parameter NPIN = 4
) (
   // clock, reset, enable
   input wire I_REF_CLK,
   input wire I_SRST,
   input wire I_CE,
   // special function register bus
   input wire [7:0] I_SFR_ADDR,
   input wire I_SFR_WR,
   input wire I_SFR_RD,
   input wire I_SFR_RMW,
   input wire [7:0] I_SFR_WDATA,
   output reg [7:0] O_SFR_RDATA,
   output reg O_SFR_HIT,
   // external data bus
   input wire [15:0] I_XBUS_ADDR,
   input wire I_XBUS_RD,
   input wire I_XBUS_WR,
   // power-down and bus strobes
   input wire I_PWR_DOWN,
   input wire I_ALE_RUN,
   input wire I_PSS_RUN,
   output reg O_ALE,
   output reg O_PSS,
   // port pins
   input wire [NPIN-1:0] I_PIN,
   output reg [NPIN-1:0] O_PIN,
   output reg [NPIN-1:0] O_PIN_OE_N,
   output reg [NPIN-1:0] O_PULLUP_EN
);

   // registers
   reg [7:0] ctrl01_r;
   reg [7:0] ctrl23_r;
   reg [7:0] polmisc_r;
   reg [7:0] latch_r;
   reg [7:0] base_hi_r [0:NPIN-1];
   reg [7:0] base_lo_r [0:NPIN-1];

   reg [7:0] rdata_nxt;
   reg hit_nxt;
   reg [NPIN-1:0] pin_nxt;
   reg [NPIN-1:0] oe_n_nxt;
   reg [NPIN-1:0] pu_nxt;
   reg [3:0] nib;
   reg [1:0] func;
   reg act;
   integer i;
   // separate loop index so the clocked and combinational loops do not share a driver
   integer j;

   // address compare, masked by the compare width
   function addr_match;
      input [15:0] addr;
      input [15:0] base;
      input [1:0] cmp;
      reg [15:0] mask;
      begin
         case (cmp)
            `ADS_CMP_A15_A0: mask = 16'hFFFF;
            `ADS_CMP_A15_A1: mask = 16'hFFFE;
            `ADS_CMP_A15_A2: mask = 16'hFFFC;
            `ADS_CMP_A15_A8: mask = 16'hFF00;
            default: mask = 16'hFFFF;
         endcase
         addr_match = ((addr & mask) == (base & mask));
      end
   endfunction

   // access type qualified by the pin function
   function strobe_req;
      input [1:0] fsel;
      input rd;
      input wr;
      begin
         case (fsel)
            `ADS_FUNC_RD: strobe_req = rd;
            `ADS_FUNC_WR: strobe_req = wr;
            `ADS_FUNC_RDWR: strobe_req = rd | wr;
            default: strobe_req = 1'b0;
         endcase
      end
   endfunction

   function [3:0] pin_nibble;
      input [1:0] idx;
      input [7:0] c01;
      input [7:0] c23;
      begin
         case (idx)
            2'h0: pin_nibble = c01[3:0];
            2'h1: pin_nibble = c01[7:4];
            2'h2: pin_nibble = c23[3:0];
            default: pin_nibble = c23[7:4];
         endcase
      end
   endfunction

   // pin drive: strobe or quasi-bidirectional latch
   always @* begin
      pin_nxt = {NPIN{1'b1}};
      oe_n_nxt = {NPIN{1'b1}};
      pu_nxt = {NPIN{1'b0}};
      nib = 4'h0;
      func = 2'h0;
      act = 1'b0;
      for (i = 0; i < NPIN; i = i + 1) begin
         nib = pin_nibble(i[1:0], ctrl01_r, ctrl23_r);
         func = nib[`ADS_NIB_FUNC_HI:`ADS_NIB_FUNC_LO];
         if (func == `ADS_FUNC_GPIO) begin
            // strong low for a 0, released on the pull-up for a 1; pull-up enabled for both
            pin_nxt[i] = latch_r[i];
            oe_n_nxt[i] = latch_r[i];
            pu_nxt[i] = 1'b1;
         end else begin
            // base from own high and low bytes
            act = strobe_req(func, I_XBUS_RD, I_XBUS_WR) &
               addr_match(I_XBUS_ADDR, {base_hi_r[i], base_lo_r[i]},
                  nib[`ADS_NIB_CMP_HI:`ADS_NIB_CMP_LO]);
            pin_nxt[i] = polmisc_r[`ADS_POL_LSB + i] ? act : ~act;
            oe_n_nxt[i] = 1'b0;
         end
      end
   end

   // register read data and decode
   always @* begin
      rdata_nxt = `ADS_RST_RDATA;
      hit_nxt = 1'b1;
      case (I_SFR_ADDR)
         `ADS_OFS_CTRL01: rdata_nxt = ctrl01_r;
         `ADS_OFS_CTRL23: rdata_nxt = ctrl23_r;
         `ADS_OFS_POLMISC: rdata_nxt = polmisc_r & `ADS_POLMISC_MASK;
         `ADS_OFS_LATCH: begin
            // rmw reads the latch unless told to use the pins
            if (I_SFR_RMW && !polmisc_r[`ADS_BIT_RMW_PIN])
               rdata_nxt = latch_r;
            else
               rdata_nxt = {latch_r[7:NPIN], I_PIN};
         end
         `ADS_OFS_BASE0H: rdata_nxt = base_hi_r[0];
         `ADS_OFS_BASE0L: rdata_nxt = base_lo_r[0];
         `ADS_OFS_BASE1H: rdata_nxt = base_hi_r[1];
         `ADS_OFS_BASE1L: rdata_nxt = base_lo_r[1];
         `ADS_OFS_BASE2H: rdata_nxt = base_hi_r[2];
         `ADS_OFS_BASE2L: rdata_nxt = base_lo_r[2];
         `ADS_OFS_BASE3H: rdata_nxt = base_hi_r[3];
         `ADS_OFS_BASE3L: rdata_nxt = base_lo_r[3];
         default: hit_nxt = 1'b0;
      endcase
   end

   // register writes
   always @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         ctrl01_r <= `ADS_RST_CTRL;
         ctrl23_r <= `ADS_RST_CTRL;
         polmisc_r <= `ADS_RST_POLMISC;
         latch_r <= `ADS_RST_LATCH;
         for (j = 0; j < NPIN; j = j + 1) begin
            base_hi_r[j] <= `ADS_RST_BASE;
            base_lo_r[j] <= `ADS_RST_BASE;
         end
      end else if (I_CE && I_SFR_WR) begin
         case (I_SFR_ADDR)
            `ADS_OFS_CTRL01: ctrl01_r <= I_SFR_WDATA;
            `ADS_OFS_CTRL23: ctrl23_r <= I_SFR_WDATA;
            `ADS_OFS_POLMISC: polmisc_r <= I_SFR_WDATA & `ADS_POLMISC_MASK;
            `ADS_OFS_LATCH: latch_r <= I_SFR_WDATA;
            `ADS_OFS_BASE0H: base_hi_r[0] <= I_SFR_WDATA;
            `ADS_OFS_BASE0L: base_lo_r[0] <= I_SFR_WDATA;
            `ADS_OFS_BASE1H: base_hi_r[1] <= I_SFR_WDATA;
            `ADS_OFS_BASE1L: base_lo_r[1] <= I_SFR_WDATA;
            `ADS_OFS_BASE2H: base_hi_r[2] <= I_SFR_WDATA;
            `ADS_OFS_BASE2L: base_lo_r[2] <= I_SFR_WDATA;
            `ADS_OFS_BASE3H: base_hi_r[3] <= I_SFR_WDATA;
            `ADS_OFS_BASE3L: base_lo_r[3] <= I_SFR_WDATA;
            default: ;
         endcase
      end
   end

   // registered outputs; strobes trail the bus by one clock
   always @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         O_SFR_RDATA <= `ADS_RST_RDATA;
         O_SFR_HIT <= 1'b0;
         O_ALE <= 1'b0;
         O_PSS <= 1'b0;
         O_PIN <= {NPIN{1'b1}};
         O_PIN_OE_N <= {NPIN{1'b1}};
         O_PULLUP_EN <= {NPIN{1'b1}};
      end else if (I_CE) begin
         O_SFR_RDATA <= I_SFR_RD ? rdata_nxt : `ADS_RST_RDATA;
         O_SFR_HIT <= (I_SFR_RD | I_SFR_WR) & hit_nxt;
         if (I_PWR_DOWN) begin
            O_ALE <= polmisc_r[`ADS_BIT_PWDN_LEVEL];
            O_PSS <= polmisc_r[`ADS_BIT_PWDN_LEVEL];
         end else begin
            O_ALE <= I_ALE_RUN;
            O_PSS <= I_PSS_RUN;
         end
         O_PIN <= pin_nxt;
         O_PIN_OE_N <= oe_n_nxt;
         O_PULLUP_EN <= pu_nxt;
      end
   end

endmodule // ads_strobe_port

// ===== tb/ads_strobe_port_chk.sv
// checker for the strobe port, bound to its top module
// assumes clock enable held high throughout
`timescale 1ns/1ps
module ads_strobe_port_chk #(parameter NPIN = 4) (
   input wire I_REF_CLK, I_SRST, I_SFR_WR, I_SFR_RD, O_SFR_HIT, I_XBUS_RD, I_XBUS_WR,
   input wire I_PWR_DOWN, I_ALE_RUN, O_ALE, O_PSS,
   input wire [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA,
   input wire [NPIN-1:0] O_PIN, O_PIN_OE_N, O_PULLUP_EN);
   logic [7:0] c01_r;
   logic lvl_r;
   // shadows of the two registers the properties lean on
   always @(posedge I_REF_CLK)
      if (I_SRST) begin
         c01_r <= 8'h00;
         lvl_r <= 1'b0;
      end else if (I_SFR_WR && I_SFR_ADDR == 8'h92) c01_r <= I_SFR_WDATA;
      else if (I_SFR_WR && I_SFR_ADDR == 8'hA2) lvl_r <= I_SFR_WDATA[2];
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SRST);
   sequence bus_idle;
      !I_XBUS_RD && !I_XBUS_WR && !I_SFR_WR;
   endsequence
   rst_state_a: assert property (disable iff (1'b0) $fell(I_SRST) |->
      O_PIN_OE_N == '1 && O_PULLUP_EN == '1 && !O_SFR_HIT) else $error("reset state wrong");
   ctrl_readback_a: assert property (I_SFR_RD && I_SFR_ADDR == 8'h92 |=>
      O_SFR_HIT && O_SFR_RDATA == $past(c01_r)) else $error("ctrl readback wrong");
   unmapped_read_a: assert property (I_SFR_RD && I_SFR_ADDR == 8'h00 |=>
      !O_SFR_HIT && O_SFR_RDATA == 8'h00) else $error("unmapped read wrong");
   misc_read_a: assert property (I_SFR_RD && I_SFR_ADDR == 8'hA2 |=>
      O_SFR_RDATA[2] == $past(lvl_r) && !O_SFR_RDATA[0]) else $error("misc read wrong");
   pwdn_level_a: assert property (I_PWR_DOWN |=>
      O_ALE == $past(lvl_r) && O_PSS == $past(lvl_r)) else $error("power-down level wrong");
   run_follow_a: assert property (!I_PWR_DOWN |=> O_ALE == $past(I_ALE_RUN))
      else $error("latch strobe not following");
   pullup_gpio_a: assert property ((O_PIN_OE_N & ~O_PULLUP_EN) == '0)
      else $error("released pin without pull-up");
   strobe_quiet_a: assert property (bus_idle ##1 bus_idle |=> $stable(O_PIN))
      else $error("pin moved with bus idle");
endmodule // ads_strobe_port_chk
bind ads_strobe_port ads_strobe_port_chk #(.NPIN(NPIN)) chk (.*);

// ===== tb/ads_periph_model.sv
// pads of the four pins with the peripherals hung on them
// assumes active-low enable; a peripheral may sink a released pad
`timescale 1ns/1ps
module ads_periph_model (
   input wire logic [3:0] i_pin, i_oe_n, i_pullup, i_ext_low,
   output logic [3:0] o_pad);
   // released pad: sink wins over the weak pull-up
   always_comb for (int k = 0; k < 4; k++)
      o_pad[k] = !i_oe_n[k] ? i_pin[k] : i_ext_low[k] ? 1'b0 : i_pullup[k];
endmodule // ads_periph_model

// ===== tb/ads_strobe_port_bench.sv
// bench for the strobe port: register tasks, pin and strobe tests
// assumes the partner model resolves pads back to the pin inputs
`timescale 1ns/1ps
module ads_strobe_port_bench;
   logic clk = 0, rst = 1, wr = 0, rd = 0, rmw = 0, xr = 0, xw = 0, pd = 0, ar = 1, pr = 1, hit, ale, pss;
   logic [7:0] a = 0, wd = 0, rdat;
   logic [15:0] xa = 0;
   logic [3:0] ext = 0, pin, oen, pu, pad;
   int fail_count = 0, checked = 0, cyc = 0;
   logic [26:0] tc [10] = '{{8'h0A, 16'h1237, 3'b011}, {8'h0A, 16'h1238, 3'b010}, {8'h0A, 16'h1234, 3'b100},
      {8'h05, 16'h1235, 3'b101}, {8'h05, 16'h1235, 3'b010}, {8'h05, 16'h1236, 3'b100},
      {8'h0C, 16'h1234, 3'b011}, {8'h0C, 16'h1235, 3'b100}, {8'h0F, 16'h12FF, 3'b101}, {8'h0F, 16'h1334, 3'b100}};
   initial forever #50 clk = ~clk;
   ads_strobe_port DUT (.I_REF_CLK(clk), .I_SRST(rst), .I_CE(1'b1), .I_SFR_ADDR(a), .I_SFR_WR(wr),
      .I_SFR_RD(rd), .I_SFR_RMW(rmw), .I_SFR_WDATA(wd), .O_SFR_RDATA(rdat), .O_SFR_HIT(hit),
      .I_XBUS_ADDR(xa), .I_XBUS_RD(xr), .I_XBUS_WR(xw), .I_PWR_DOWN(pd), .I_ALE_RUN(ar), .I_PSS_RUN(pr),
      .O_ALE(ale), .O_PSS(pss), .I_PIN(pad), .O_PIN(pin), .O_PIN_OE_N(oen), .O_PULLUP_EN(pu));
   ads_periph_model PM (.i_pin(pin), .i_oe_n(oen), .i_pullup(pu), .i_ext_low(ext), .o_pad(pad));
   task give_verdict;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmp(input string n, input logic [7:0] e, s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task w(input logic [7:0] ad, d);
      @(posedge clk) {a, wd, wr} <= {ad, d, 1'b1};
      @(posedge clk) wr <= 0;
   endtask
   task r(input logic [7:0] ad, e, input logic m);
      @(posedge clk) {a, rd, rmw} <= {ad, 1'b1, m};
      @(posedge clk) {rd, rmw} <= 2'b00;
      #1 cmp("rdata", e, rdat);
   endtask
   // strobe only lands one cycle after the bus strobe, so look a cycle late
   task x(input logic [15:0] ad, input logic rr, ww, input logic [3:0] e, i);
      @(posedge clk) {xa, xr, xw} <= {ad, rr, ww};
      @(posedge clk) {xr, xw} <= 2'b00;
      #1 cmp("strobe", {4'h0, e}, {4'h0, pin});
      @(posedge clk) #1 cmp("idle", {4'h0, i}, {4'h0, pin});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         give_verdict;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      r(8'h92, 8'h00, 0);
      r(8'hA3, 8'hFF, 0);
      r(8'h00, 8'h00, 0);
      w(8'hA2, 8'hFF);
      r(8'hA2, 8'hF6, 0);
      $display("regs done");
      w(8'hA3, 8'hF5);
      // pin drive is registered, so it shows one clock after the latch write
      @(posedge clk) #1 cmp("oe_n", 8'h05, {4'h0, oen});
      ext <= 4'h1;
      r(8'hA3, 8'hF4, 1);
      w(8'hA2, 8'h00);
      r(8'hA3, 8'hF5, 1);
      r(8'hA3, 8'hF4, 0);
      ext <= 4'h0;
      $display("gpio done");
      w(8'hA4, 8'h12);
      w(8'hA5, 8'h34);
      r(8'hA4, 8'h12, 0);
      w(8'hA2, 8'h10);
      for (int k = 0; k < 10; k++) begin
         w(8'h92, tc[k][26:19]);
         x(tc[k][18:3], tc[k][2], tc[k][1], {3'b010, tc[k][0]}, 4'h4);
      end
      w(8'h93, 8'hF0);
      w(8'hAA, 8'h56);
      w(8'hA2, 8'h80);
      x(16'h56AA, 1, 0, 4'hD, 4'h5);
      x(16'h12AA, 0, 1, 4'h4, 4'h5);
      $display("strobe done");
      {ar, pr, pd} <= 3'b001;
      w(8'hA2, 8'h04);
      @(posedge clk) #1 cmp("pwdn", 8'h03, {6'h0, ale, pss});
      w(8'hA2, 8'h00);
      @(posedge clk) #1 cmp("pwdn", 8'h00, {6'h0, ale, pss});
      {ar, pr, pd} <= 3'b110;
      repeat (2) @(posedge clk);
      #1 cmp("run", 8'h03, {6'h0, ale, pss});
      $display("pwdn done");
      give_verdict;
   end
endmodule // ads_strobe_port_bench
